// File: hdl/dmia_decoder.sv
// data memory address decoder with indirect access through pointer registers
//
// Function
// - a read of an unused special location returns zero.
// - protected special locations ignore writes; other special registers take reads and writes.
// - an indirect port redirects its access to the byte that its pointer selects.
// - the sector-0 port with its single pointer reaches only sector 0.
// - ports a and b with two-byte pointers reach any sector.
// - the high pointer byte selects the sector and the low byte the address within it.
// - an access that lands on an indirect port itself reads zero and writes nothing.
// - all five pointer bytes are real storage, readable and writable like any register.
// - extended-form direct addresses reach every sector without the pointers.
// - low byte 00h..7fh is the special area, 80h..ffh general storage.
// - an extended direct address uses bit 8 as sector and bits 7:0 as the byte.
`timescale 1ns/10ps
`default_nettype none
module dmia_decoder (
  input  wire logic                               clk_sys,
  input  wire logic                               sys_rst,
  input  wire logic                               acc_valid,
  input  wire logic                               acc_write,
  input  wire logic                               acc_ext,
  input  wire logic [dmia_pkg::DMIA_ADDR_W-1:0]   acc_addr,
  input  wire logic [7:0]                         acc_wdata,
  output var  logic                               acc_rvalid,
  output var  logic [7:0]                         acc_rdata,
  output var  logic                               sfr_sel,
  output var  logic                               sfr_write,
  output var  logic [6:0]                         sfr_addr,
  output var  logic [7:0]                         sfr_wdata,
  input  wire logic [7:0]                         sfr_rdata,
  input  wire logic                               sfr_rd_ok,
  input  wire logic                               sfr_wr_ok
);
  import dmia_pkg::*;

  // -----------------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------------
  // is this byte one of the three indirect ports
  function automatic logic is_port(input logic [7:0] a);
    is_port = (a == DMIA_OFS_PORT_S0) || (a == DMIA_OFS_PORT_A) || (a == DMIA_OFS_PORT_B);
  endfunction : is_port

  // is this byte a pointer register
  function automatic logic is_ptr(input logic [7:0] a);
    is_ptr = (a == DMIA_OFS_PTR_S0) || (a == DMIA_OFS_PTR_A_LO) || (a == DMIA_OFS_PTR_A_SC)
          || (a == DMIA_OFS_PTR_B_LO) || (a == DMIA_OFS_PTR_B_SC);
  endfunction : is_ptr

  // -----------------------------------------------------------------------
  // pointer storage
  // -----------------------------------------------------------------------
  logic [7:0] ptr_s0_reg;
  logic [7:0] ptr_a_lo_reg;
  logic [7:0] ptr_a_sc_reg;
  logic [7:0] ptr_b_lo_reg;
  logic [7:0] ptr_b_sc_reg;

  // -----------------------------------------------------------------------
  // effective address
  // -----------------------------------------------------------------------
  logic [DMIA_ADDR_W-1:0] eff_addr;
  logic                   via_port;
  logic [7:0]             req_low;

  // standard forms address sector 0 directly and reach sector 1 only through ports a and b; extended forms carry the sector bit
  always_comb begin
    req_low  = acc_addr[7:0];
    via_port = 1'b0;
    if (acc_ext) begin
      eff_addr = acc_addr;
    end else begin
      eff_addr = {1'b0, req_low};
    end
    if (eff_addr[8] == 1'b0) begin
      unique case (req_low)
        DMIA_OFS_PORT_S0: begin
          eff_addr = {1'b0, ptr_s0_reg};
          via_port = 1'b1;
        end
        DMIA_OFS_PORT_A: begin
          eff_addr = {ptr_a_sc_reg[0], ptr_a_lo_reg};
          via_port = 1'b1;
        end
        DMIA_OFS_PORT_B: begin
          eff_addr = {ptr_b_sc_reg[0], ptr_b_lo_reg};
          via_port = 1'b1;
        end
        default: begin
          via_port = 1'b0;
        end
      endcase
    end
  end

  // region of the final target
  logic tgt_gp;
  logic tgt_port;
  logic tgt_ptr;
  logic tgt_sfr;
  always_comb begin
    tgt_gp   = eff_addr[DMIA_SP_BIT];
    tgt_port = !tgt_gp && (eff_addr[8] == 1'b0) && is_port(eff_addr[7:0]);
    tgt_ptr  = !tgt_gp && (eff_addr[8] == 1'b0) && is_ptr(eff_addr[7:0]);
    tgt_sfr  = !tgt_gp && !tgt_port && !tgt_ptr && (eff_addr[8] == 1'b0);
  end

  logic do_wr;
  assign do_wr = acc_valid && acc_write;

  // pointers take any write whose effective address names them, including one made through an indirect port
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ptr_s0_reg   <= DMIA_PTR_RST;
      ptr_a_lo_reg <= DMIA_PTR_RST;
      ptr_a_sc_reg <= DMIA_PTR_RST;
      ptr_b_lo_reg <= DMIA_PTR_RST;
      ptr_b_sc_reg <= DMIA_PTR_RST;
    end else if (do_wr && tgt_ptr) begin
      unique case (eff_addr[7:0])
        DMIA_OFS_PTR_S0:   ptr_s0_reg   <= acc_wdata;
        DMIA_OFS_PTR_A_LO: ptr_a_lo_reg <= acc_wdata;
        DMIA_OFS_PTR_A_SC: ptr_a_sc_reg <= acc_wdata;
        DMIA_OFS_PTR_B_LO: ptr_b_lo_reg <= acc_wdata;
        DMIA_OFS_PTR_B_SC: ptr_b_sc_reg <= acc_wdata;
        default:           ptr_s0_reg   <= ptr_s0_reg;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // general purpose storage
  // -----------------------------------------------------------------------
  logic [7:0] ram_addr;
  logic [7:0] ram_rdata;
  assign ram_addr = {eff_addr[8], eff_addr[6:0]};

  dmia_ram u_ram (
    .clk_sys    (clk_sys),
    .we         (do_wr && tgt_gp),
    .unused_tie ({1'b0, 1'b0}),
    .addr       (ram_addr),
    .wdata      (acc_wdata),
    .rdata      (ram_rdata)
  );

  // -----------------------------------------------------------------------
  // special register strobe to the peripheral registers
  // -----------------------------------------------------------------------
  // sector 1 special area is all unused, so only sector 0 is forwarded
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sfr_sel   <= 1'b0;
      sfr_write <= 1'b0;
      sfr_addr  <= 7'h00;
      sfr_wdata <= 8'h00;
    end else begin
      sfr_sel   <= acc_valid && tgt_sfr;
      sfr_write <= do_wr && tgt_sfr && sfr_wr_ok;
      sfr_addr  <= eff_addr[6:0];
      sfr_wdata <= acc_wdata;
    end
  end

  // -----------------------------------------------------------------------
  // read answer, rvalid one cycle after the request and data two cycles after
  // -----------------------------------------------------------------------
  typedef enum logic [1:0] { DMIA_SRC_ZERO, DMIA_SRC_PTR, DMIA_SRC_GP, DMIA_SRC_SFR } dmia_src_e;
  dmia_src_e  src_reg;
  logic [7:0] ptr_q_reg;
  logic       sfr_ok_reg;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acc_rvalid <= 1'b0;
      src_reg    <= DMIA_SRC_ZERO;
      ptr_q_reg  <= DMIA_RD_ZERO;
      sfr_ok_reg <= 1'b0;
    end else begin
      acc_rvalid <= acc_valid && !acc_write;
      sfr_ok_reg <= sfr_rd_ok;
      if (tgt_gp) begin
        src_reg <= DMIA_SRC_GP;
      end else if (tgt_ptr) begin
        src_reg <= DMIA_SRC_PTR;
      end else if (tgt_sfr) begin
        src_reg <= DMIA_SRC_SFR;
      end else begin
        src_reg <= DMIA_SRC_ZERO;
      end
      unique case (eff_addr[7:0])
        DMIA_OFS_PTR_S0:   ptr_q_reg <= ptr_s0_reg;
        DMIA_OFS_PTR_A_LO: ptr_q_reg <= ptr_a_lo_reg;
        DMIA_OFS_PTR_A_SC: ptr_q_reg <= ptr_a_sc_reg;
        DMIA_OFS_PTR_B_LO: ptr_q_reg <= ptr_b_lo_reg;
        DMIA_OFS_PTR_B_SC: ptr_q_reg <= ptr_b_sc_reg;
        default:           ptr_q_reg <= DMIA_RD_ZERO;
      endcase
    end
  end

  // output mux is a register so the data port comes straight from a flop;
  // data therefore lands one cycle behind rvalid, the sfr answer being sampled then
  logic [7:0] rdata_next;
  always_comb begin
    unique case (src_reg)
      DMIA_SRC_GP:   rdata_next = ram_rdata;
      DMIA_SRC_PTR:  rdata_next = ptr_q_reg;
      DMIA_SRC_SFR:  rdata_next = sfr_ok_reg ? sfr_rdata : DMIA_RD_ZERO;
      DMIA_SRC_ZERO: rdata_next = DMIA_RD_ZERO;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acc_rdata <= DMIA_RD_ZERO;
    end else begin
      acc_rdata <= rdata_next;
    end
  end

  logic unused_via;
  assign unused_via = via_port;
endmodule : dmia_decoder
`default_nettype wire

// File: hdl/dmia_pkg.sv
// package: address map, field positions and reset values for the data memory decoder
package dmia_pkg;

  // -----------------------------------------------------------------------
  // address layout
  // -----------------------------------------------------------------------
  localparam int unsigned DMIA_SECT_W   = 1;             // sectors 0 and 1
  localparam int unsigned DMIA_ADDR_W   = 9;             // sector bit + byte
  localparam int unsigned DMIA_SECTORS  = 2;
  localparam int unsigned DMIA_GP_WORDS = 128;           // per sector
  localparam int unsigned DMIA_SP_WORDS = 128;           // sector 0 special area
  localparam int unsigned DMIA_SP_BIT   = 7;             // low byte bit 7 clear = special area

  // -----------------------------------------------------------------------
  // register offsets
  // -----------------------------------------------------------------------
  localparam logic [7:0] DMIA_OFS_PORT_S0  = 8'h00;      // indirect_port_sector0
  localparam logic [7:0] DMIA_OFS_PTR_S0   = 8'h01;      // pointer_sector0
  localparam logic [7:0] DMIA_OFS_PORT_A   = 8'h02;      // indirect_port_a
  localparam logic [7:0] DMIA_OFS_PTR_A_LO = 8'h03;      // pointer_a_low
  localparam logic [7:0] DMIA_OFS_PTR_A_SC = 8'h04;      // pointer_a_sector
  localparam logic [7:0] DMIA_OFS_PORT_B   = 8'h0c;      // indirect_port_b
  localparam logic [7:0] DMIA_OFS_PTR_B_LO = 8'h0d;      // pointer_b_low
  localparam logic [7:0] DMIA_OFS_PTR_B_SC = 8'h0e;      // pointer_b_sector

  // -----------------------------------------------------------------------
  // reset values and fixed answers
  // -----------------------------------------------------------------------
  localparam logic [7:0] DMIA_PTR_RST  = 8'h00;
  localparam logic [7:0] DMIA_RD_ZERO  = 8'h00;
  localparam logic [7:0] DMIA_GP_RST   = 8'h00;

endpackage : dmia_pkg

// File: hdl/dmia_ram.sv
// single port general purpose storage for all sectors, synchronous read
`timescale 1ns/10ps
`default_nettype none
module dmia_ram (
  input  wire logic                          clk_sys,
  input  wire logic                          we,
  input  wire logic [dmia_pkg::DMIA_SECT_W:0] unused_tie,
  input  wire logic [7:0]                    addr,
  input  wire logic [7:0]                    wdata,
  output var  logic [7:0]                    rdata
);
  import dmia_pkg::*;

  // -----------------------------------------------------------------------
  // storage array, index = {sector, low seven address bits}
  // -----------------------------------------------------------------------
  logic [7:0] mem [0:DMIA_SECTORS*DMIA_GP_WORDS-1];

  // write and read share the clock; read returns old data on collision
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

  logic unused_ok;
  assign unused_ok = ^unused_tie;
endmodule : dmia_ram
`default_nettype wire

// File: verif/dmia_checker.sv
// port assertions for the data memory decoder
`timescale 1ns/10ps
`default_nettype none
module dmia_checker (
  input wire logic                             clk_sys,
  input wire logic                             sys_rst,
  input wire logic                             acc_valid,
  input wire logic                             acc_write,
  input wire logic                             acc_ext,
  input wire logic [dmia_pkg::DMIA_ADDR_W-1:0] acc_addr,
  input wire logic [7:0]                       acc_wdata,
  input wire logic                             acc_rvalid,
  input wire logic [7:0]                       acc_rdata,
  input wire logic                             sfr_sel,
  input wire logic                             sfr_write,
  input wire logic [6:0]                       sfr_addr,
  input wire logic [7:0]                       sfr_wdata,
  input wire logic [7:0]                       sfr_rdata,
  input wire logic                             sfr_rd_ok,
  input wire logic                             sfr_wr_ok
);
  import dmia_pkg::*;
  logic rd_req;
  logic wr_req;
  logic periph;
  // peripheral target: sector 0 special area minus ports and pointers
  assign rd_req = acc_valid && !acc_write;
  assign wr_req = acc_valid && acc_write;
  assign periph = !acc_addr[7] && !(acc_ext && acc_addr[8]) &&
                  !(acc_addr[6:0] inside {7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h0c, 7'h0d, 7'h0e});
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_ans; rd_req |=> acc_rvalid; endproperty
  a_ans: assert property (p_ans) else $error("read not answered");
  property p_no_ans; !rd_req |=> !acc_rvalid; endproperty
  a_no_ans: assert property (p_no_ans) else $error("answer without read");
  property p_sel; acc_valid && periph |=> sfr_sel && sfr_addr == $past(acc_addr[6:0]); endproperty
  a_sel: assert property (p_sel) else $error("special access not forwarded");
  property p_no_sel; !(acc_valid && periph) |=> !sfr_sel && !sfr_write; endproperty
  a_no_sel: assert property (p_no_sel) else $error("stray peripheral access");
  property p_prot; wr_req && periph && !sfr_wr_ok |=> !sfr_write; endproperty
  a_prot: assert property (p_prot) else $error("protected write forwarded");
  property p_fwd; wr_req && periph && sfr_wr_ok |=> sfr_write && sfr_wdata == $past(acc_wdata); endproperty
  a_fwd: assert property (p_fwd) else $error("write not forwarded");
  property p_unused; rd_req && periph && !sfr_rd_ok |-> ##2 acc_rdata == 8'h00; endproperty
  a_unused: assert property (p_unused) else $error("unused read not zero");
  property p_s1; rd_req && acc_ext && acc_addr[8:7] == 2'b10 |-> ##2 acc_rdata == 8'h00; endproperty
  a_s1: assert property (p_s1) else $error("sector 1 special read not zero");
  property p_sfrrd; rd_req && periph && sfr_rd_ok |=> ##1 acc_rdata == $past(sfr_rdata); endproperty
  a_sfrrd: assert property (p_sfrrd) else $error("peripheral data lost");
endmodule : dmia_checker
bind dmia_decoder dmia_checker chk_u (.clk_sys, .sys_rst, .acc_valid, .acc_write, .acc_ext, .acc_addr,
  .acc_wdata, .acc_rvalid, .acc_rdata, .sfr_sel, .sfr_write, .sfr_addr, .sfr_wdata, .sfr_rdata,
  .sfr_rd_ok, .sfr_wr_ok);
`default_nettype wire

// File: verif/dmia_sfr_model.sv
// peripheral special registers seen behind the decoder
`timescale 1ns/10ps
`default_nettype none
module dmia_sfr_model (
  input  wire logic                             clk_sys,
  input  wire logic [dmia_pkg::DMIA_ADDR_W-1:0] acc_addr,
  input  wire logic                             sfr_sel,
  input  wire logic                             sfr_write,
  input  wire logic [6:0]                       sfr_addr,
  input  wire logic [7:0]                       sfr_wdata,
  output logic      [7:0]                       sfr_rdata,
  output logic                                  sfr_rd_ok,
  output logic                                  sfr_wr_ok
);
  import dmia_pkg::*;
  logic [7:0] regs [0:127];
  initial for (int i = 0; i < 128; i++) regs[i] = 8'h00;
  // 77h..7fh unused, 0ah read-only; deselected bus shows inverse data
  assign sfr_rd_ok = acc_addr[6:0] <= 7'h76;
  assign sfr_wr_ok = sfr_rd_ok && acc_addr[6:0] != 7'h0a;
  assign sfr_rdata = sfr_sel ? regs[sfr_addr] : ~regs[sfr_addr];
  always @(posedge clk_sys) if (sfr_write) regs[sfr_addr] <= sfr_wdata;
endmodule : dmia_sfr_model
`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench for the data memory decoder
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import dmia_pkg::*;
  logic                   clk_sys, sys_rst, acc_valid, acc_write, acc_ext, acc_rvalid;
  logic                   sfr_sel, sfr_write, sfr_rd_ok, sfr_wr_ok, e;
  logic [DMIA_ADDR_W-1:0] acc_addr, a;
  logic [7:0]             acc_wdata, acc_rdata, sfr_wdata, sfr_rdata, d;
  logic [6:0]             sfr_addr;
  logic [9:0]             r;
  logic [7:0]             m [0:511];
  logic [8:0]             sp [0:7] = '{9'h000, 9'h001, 9'h002, 9'h003, 9'h004, 9'h00c, 9'h00d, 9'h00e};
  int                     n_mismatch, check_count;
  dmia_decoder dut_u (.clk_sys, .sys_rst, .acc_valid, .acc_write, .acc_ext, .acc_addr, .acc_wdata,
    .acc_rvalid, .acc_rdata, .sfr_sel, .sfr_write, .sfr_addr, .sfr_wdata, .sfr_rdata, .sfr_rd_ok, .sfr_wr_ok);
  dmia_sfr_model sfr_u (.clk_sys, .acc_addr, .sfr_sel, .sfr_write, .sfr_addr, .sfr_wdata, .sfr_rdata,
    .sfr_rd_ok, .sfr_wr_ok);
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // target after one redirection, top bit set when it holds storage
  function automatic logic [9:0] res(input logic ex, input logic [8:0] ad);
    logic [8:0] t;
    t = {ex & ad[8], ad[7:0]};
    if (t == 9'h000) t = {1'b0, m[1]};
    else if (t == 9'h002) t = {m[4][0], m[3]};
    else if (t == 9'h00c) t = {m[14][0], m[13]};
    return {!(!t[7] && (t[8] || t[6:0] inside {7'h00, 7'h02, 7'h0c} || t[6:0] > 7'h76)), t};
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // valid stays up so writes and a following read run back to back
  task automatic wr(input logic ex, input logic [8:0] ad, input logic [7:0] dt);
    logic [9:0] q;
    q = res(ex, ad);
    {acc_valid, acc_write, acc_ext, acc_addr, acc_wdata} = {2'b11, ex, ad, dt};
    if (q[9] && q[8:0] != 9'h00a) m[q[8:0]] = dt;
    @(negedge clk_sys);
  endtask
  task automatic rd(input logic ex, input logic [8:0] ad);
    logic [9:0] q;
    q = res(ex, ad);
    {acc_valid, acc_write, acc_ext, acc_addr} = {2'b10, ex, ad};
    @(negedge clk_sys) acc_valid = 1'b0;
    chk("rvalid", 8'h01, {7'h00, acc_rvalid});
    @(negedge clk_sys) chk("rdata", q[9] ? m[q[8:0]] : 8'h00, acc_rdata);
    chk("rvalid_end", 8'h00, {7'h00, acc_rvalid});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #(50 * 20000);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    {sys_rst, acc_valid, acc_write, acc_ext, acc_addr, acc_wdata} = {1'b1, 20'h0};
    for (int i = 0; i < 512; i++) m[i] = 8'h00;
    void'($urandom(1));
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    for (int i = 0; i < 8; i++) rd(1'b0, sp[i]);
    for (int i = 128; i < 512; i++) if (i[7]) wr(1'b1, 9'(i), 8'($urandom));
    wr(1'b0, 9'h001, 8'h03); rd(1'b0, 9'h100);
    wr(1'b0, 9'h001, 8'h02); wr(1'b0, 9'h000, 8'h5a); rd(1'b0, 9'h000);
    wr(1'b0, 9'h00a, 8'hff); rd(1'b0, 9'h00a);
    rd(1'b1, 9'h105); rd(1'b0, 9'h07f);
    repeat (400) begin
      e = 1'($urandom);
      a = ($urandom % 2) ? 9'($urandom) : {1'($urandom), sp[$urandom % 8][7:0]};
      d = 8'($urandom);
      r = res(e, a);
      if (r[8:0] inside {9'h001, 9'h003, 9'h00d}) d[7] = 1'b1; // ports stay off peripherals
      if ($urandom % 2) wr(e, a, d); else rd(e, a);
    end
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
